// ---- logic/pct_pkg.sv ----
// Package for the protection comparator trim control block
package pct_pkg;
    // ------------------------------------------------------------
    // Register indices (word address on the plain register port)
    // ------------------------------------------------------------
    localparam logic [2:0] PCT_ADDR_DAC_CODE = 3'h0;   // Threshold DAC code
    localparam logic [2:0] PCT_ADDR_AMP_CAL = 3'h1;    // Amplifier trim and mode
    localparam logic [2:0] PCT_ADDR_CMP_CAL = 3'h2;    // Comparator trim, mode, raw out
    localparam logic [2:0] PCT_ADDR_SWITCH = 3'h3;     // Analog switch control byte
    localparam logic [2:0] PCT_ADDR_CTRL = 3'h4;       // Enable, hysteresis, input select
    localparam logic [2:0] PCT_ADDR_DEBOUNCE = 3'h5;   // Debounce select
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] PCT_RST_DAC_CODE = 8'h00;
    localparam logic [7:0] PCT_RST_AMP_CAL = 8'h20;
    localparam logic [7:0] PCT_RST_CMP_CAL = 8'h10;
    localparam logic [7:0] PCT_RST_SWITCH = 8'hC8;
    localparam logic [7:0] PCT_RST_CTRL = 8'h00;
    localparam logic [2:0] PCT_RST_DEBOUNCE = 3'h0;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int PCT_AMP_MODE_BIT = 7;
    localparam int PCT_AMP_REF_BIT = 6;
    localparam int PCT_CMP_OUT_BIT = 7;
    localparam int PCT_CMP_MODE_BIT = 6;
    localparam int PCT_CMP_REF_BIT = 5;
    localparam int PCT_CTRL_EN_BIT = 7;
    localparam int PCT_CTRL_HYST_BIT = 6;
    localparam int PCT_CTRL_FILT_BIT = 5;
    localparam int PCT_CTRL_PLUS_BIT = 1;
    localparam int PCT_CTRL_VREF_BIT = 0;
    localparam int PCT_SW_GAIN_LO = 4;
    localparam int PCT_SW_GAIN_HI = 6;
    // ------------------------------------------------------------
    // Debounce timing: one debounce period is one system clock
    // ------------------------------------------------------------
    localparam int PCT_DEBOUNCE_PERIOD_PS = 5000;
    localparam int PCT_CLOCK_PERIOD_PS = 5000;
    localparam int PCT_DEBOUNCE_CYCLES = (PCT_DEBOUNCE_PERIOD_PS + PCT_CLOCK_PERIOD_PS - 1)
                                         / PCT_CLOCK_PERIOD_PS;
    localparam int PCT_DEB_CNT_W = 8;
endpackage

// ---- logic/pct_debounce.sv ----
// Debounce filter for the raw comparator output
`timescale 1ns/1ps
module pct_debounce
    import pct_pkg::*;
#(
    parameter int CNT_W = pct_pkg::PCT_DEB_CNT_W
)
(
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic [2:0] i_select,
    input wire logic i_raw,
    output logic o_filtered
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed
    {
        logic [CNT_W-1:0] count;    // Cycles the raw level has differed
        logic filt;                 // Filtered output
    } pct_deb_s;

    pct_deb_s state_reg;
    pct_deb_s state_next;
    logic [CNT_W-1:0] limit;

    // Stable length needed: 2^sel - 1 cycles including the first; the
    // unknown phase of the change gives the (n-1 ~ n) window
    always_comb
    begin
        limit = CNT_W'((CNT_W+1)'(1) << i_select) - CNT_W'(1);
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        if (i_select == 3'h0)
        begin
            state_next.filt = i_raw;
            state_next.count = '0;
        end
        else if (i_raw == state_reg.filt)
        begin
            state_next.count = '0;
        end
        else if (state_reg.count >= limit - CNT_W'(PCT_DEBOUNCE_CYCLES))
        begin
            state_next.filt = i_raw;
            state_next.count = '0;
        end
        else
        begin
            state_next.count = state_reg.count + CNT_W'(1);
        end
    end

    // Register; counts every system clock edge
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    assign o_filtered = state_reg.filt;
endmodule

// ---- logic/pct_top.sv ----
// Protection comparator trim control: registers, analog controls, debounce
//
// Functional notes
// - Select zero bypasses debounce entirely.
// - Other selects need stable input for 2^n - 1 cycles.
// - Debounce counts system clock cycles.
// - Eight-bit threshold code, reset zero, drives DAC.
// - Enable low forces raw comparator to zero.
// - Amplifier mode bit seven selects calibration.
// - Amplifier reference bit six selects input.
// - Six-bit amplifier trim drives offset adjust.
// - Comparator bit seven shows raw result, read-only.
// - Comparator mode bit six selects calibration.
// - Comparator reference bit five selects input.
// - Five-bit comparator trim drives offset adjust.
// - Switches six to four zero: unity buffer.
`timescale 1ns/1ps
module pct_top
    import pct_pkg::*;
#(
    parameter int DEB_CNT_W = pct_pkg::PCT_DEB_CNT_W
)
(
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic [2:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_write,
    input wire logic i_read,
    output logic [7:0] o_rdata,
    input wire logic i_cmp_analog,
    output logic o_cmp_filtered,
    output logic o_protect_enable,
    output logic [7:0] o_dac_code,
    output logic o_dac_vref_select,
    output logic [7:0] o_analog_switch_ctrl,
    output logic o_unity_buffer,
    output logic o_hysteresis_enable,
    output logic o_cmp_plus_input_select,
    output logic o_amp_cal_mode,
    output logic o_amp_cal_ref_select,
    output logic [5:0] o_amp_trim,
    output logic o_cmp_cal_mode,
    output logic o_cmp_cal_ref_select,
    output logic [4:0] o_cmp_trim
);
    import pct_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed
    {
        logic [7:0] dac_code;       // Threshold DAC code
        logic [7:0] amp_cal;        // Mode, reference, six-bit trim
        logic [6:0] cmp_cal;        // Mode, reference, five-bit trim
        logic [7:0] switches;       // Analog switch control byte
        logic enable;               // Protect function enable
        logic hyst;                 // Hysteresis enable
        logic plus_sel;             // Comparator plus input select
        logic vref_sel;             // DAC reference select
        logic [2:0] deb_sel;        // Debounce select
        logic raw;                  // Gated, registered raw compare out
        logic unity;                // Unity buffer indication
        logic filt;                 // Registered filtered output
        logic [7:0] rdata;          // Read data, valid one cycle
    } pct_top_s;

    pct_top_s state_reg;
    pct_top_s state_next;
    logic deb_out;

    // Reset image of the whole state
    function automatic pct_top_s reset_state();
        pct_top_s s;
        s = '0;
        s.dac_code = PCT_RST_DAC_CODE;
        s.amp_cal = PCT_RST_AMP_CAL;
        s.cmp_cal = PCT_RST_CMP_CAL[6:0];
        s.switches = PCT_RST_SWITCH;
        s.enable = PCT_RST_CTRL[PCT_CTRL_EN_BIT];
        s.deb_sel = PCT_RST_DEBOUNCE;
        return s;
    endfunction

    // Unity buffer when the three gain switches are all off
    function automatic logic is_unity(input logic [7:0] sw);
        return sw[PCT_SW_GAIN_HI:PCT_SW_GAIN_LO] == 3'h0;
    endfunction

    // ------------------------------------------------------------
    // Debounce filter
    // ------------------------------------------------------------
    pct_debounce #(
        .CNT_W(DEB_CNT_W)
    ) u_debounce (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_select(state_reg.deb_sel),
        .i_raw(state_reg.raw),
        .o_filtered(deb_out)
    );

    // ------------------------------------------------------------
    // Next state: register writes, reads, comparator sampling
    // ------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        // Disabled circuit reads raw output as zero
        state_next.raw = state_reg.enable & i_cmp_analog;
        state_next.filt = deb_out;
        state_next.rdata = 8'h00;
        if (i_write)
        begin
            unique case (i_addr)
                PCT_ADDR_DAC_CODE: state_next.dac_code = i_wdata;
                PCT_ADDR_AMP_CAL: state_next.amp_cal = i_wdata;
                PCT_ADDR_CMP_CAL: state_next.cmp_cal = i_wdata[6:0];
                PCT_ADDR_SWITCH: state_next.switches = i_wdata;
                PCT_ADDR_CTRL:
                begin
                    state_next.enable = i_wdata[PCT_CTRL_EN_BIT];
                    state_next.hyst = i_wdata[PCT_CTRL_HYST_BIT];
                    state_next.plus_sel = i_wdata[PCT_CTRL_PLUS_BIT];
                    state_next.vref_sel = i_wdata[PCT_CTRL_VREF_BIT];
                end
                PCT_ADDR_DEBOUNCE: state_next.deb_sel = i_wdata[2:0];
                default:
                begin
                    // Unmapped writes are ignored
                end
            endcase
        end
        if (i_read)
        begin
            unique case (i_addr)
                PCT_ADDR_DAC_CODE: state_next.rdata = state_reg.dac_code;
                PCT_ADDR_AMP_CAL: state_next.rdata = state_reg.amp_cal;
                // Bit seven is live status; writes never touch it
                PCT_ADDR_CMP_CAL: state_next.rdata = {state_reg.raw, state_reg.cmp_cal};
                PCT_ADDR_SWITCH: state_next.rdata = state_reg.switches;
                PCT_ADDR_CTRL:
                begin
                    state_next.rdata[PCT_CTRL_EN_BIT] = state_reg.enable;
                    state_next.rdata[PCT_CTRL_HYST_BIT] = state_reg.hyst;
                    state_next.rdata[PCT_CTRL_FILT_BIT] = state_reg.filt;
                    state_next.rdata[PCT_CTRL_PLUS_BIT] = state_reg.plus_sel;
                    state_next.rdata[PCT_CTRL_VREF_BIT] = state_reg.vref_sel;
                end
                PCT_ADDR_DEBOUNCE: state_next.rdata = {5'h00, state_reg.deb_sel};
                default: state_next.rdata = 8'h00;   // Unmapped reads as zero
            endcase
        end
        state_next.unity = is_unity(state_next.switches);
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
            state_reg <= reset_state();
        else
            state_reg <= state_next;
    end

    // ------------------------------------------------------------
    // Outputs, all straight from the state register
    // ------------------------------------------------------------
    assign o_rdata = state_reg.rdata;
    assign o_cmp_filtered = state_reg.filt;
    assign o_protect_enable = state_reg.enable;
    assign o_dac_code = state_reg.dac_code;
    assign o_dac_vref_select = state_reg.vref_sel;
    assign o_analog_switch_ctrl = state_reg.switches;
    assign o_unity_buffer = state_reg.unity;
    assign o_hysteresis_enable = state_reg.hyst;
    assign o_cmp_plus_input_select = state_reg.plus_sel;
    assign o_amp_cal_mode = state_reg.amp_cal[PCT_AMP_MODE_BIT];
    assign o_amp_cal_ref_select = state_reg.amp_cal[PCT_AMP_REF_BIT];
    assign o_amp_trim = state_reg.amp_cal[5:0];
    assign o_cmp_cal_mode = state_reg.cmp_cal[PCT_CMP_MODE_BIT];
    assign o_cmp_cal_ref_select = state_reg.cmp_cal[PCT_CMP_REF_BIT];
    assign o_cmp_trim = state_reg.cmp_cal[4:0];
endmodule

// ---- tb/pct_top_asserts.sv ----
// Assertion checker bound to the protection comparator trim block
`timescale 1ns/1ps
module pct_top_asserts (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic [2:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_write,
    input wire logic i_read,
    input wire logic [7:0] o_rdata,
    input wire logic i_cmp_analog,
    input wire logic o_cmp_filtered,
    input wire logic o_protect_enable,
    input wire logic [7:0] o_dac_code,
    input wire logic o_unity_buffer,
    input wire logic o_amp_cal_mode,
    input wire logic o_amp_cal_ref_select,
    input wire logic [5:0] o_amp_trim,
    input wire logic o_cmp_cal_mode,
    input wire logic o_cmp_cal_ref_select,
    input wire logic [4:0] o_cmp_trim
);
    // ------------------------------------------------------------
    // Helper shadows: select field and hold time of gated input
    // ------------------------------------------------------------
    logic [2:0] sel_reg; // Mirror of debounce select
    logic [8:0] hold_reg; // Saturating count of still cycles
    logic gate_reg; // Gated input one cycle ago
    logic gate; // Comparator gated by enable
    assign gate = i_cmp_analog & o_protect_enable;
    // Counter saturates so long idle stretches never wrap
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            sel_reg <= 3'h0;
            hold_reg <= 9'h000;
            gate_reg <= 1'b0;
        end
        else
        begin
            if (i_write && i_addr == 3'h5)
                sel_reg <= i_wdata[2:0];
            gate_reg <= gate;
            hold_reg <= (gate != gate_reg) ? 9'h000 : hold_reg + {8'h00, hold_reg != 9'h1FF};
        end
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    a_dac_write:
    assert property (i_write && i_addr == 3'h0 |=> o_dac_code == $past(i_wdata))
        else $error("dac code not taken from write");
    a_amp_write:
    assert property (i_write && i_addr == 3'h1 |=>
        {o_amp_cal_mode, o_amp_cal_ref_select, o_amp_trim} == $past(i_wdata))
        else $error("amplifier fields not taken from write");
    a_cmp_write:
    assert property (i_write && i_addr == 3'h2 |=>
        {o_cmp_cal_mode, o_cmp_cal_ref_select, o_cmp_trim} == $past(i_wdata[6:0]))
        else $error("comparator fields not taken from write");
    a_disable_zero:
    assert property (!o_protect_enable [*3] ##0 (i_read && i_addr == 3'h2) |=> !o_rdata[7])
        else $error("raw bit set while disabled");
    a_bypass_follow:
    assert property ((sel_reg == 3'h0) [*4] |->
        o_cmp_filtered == $past(gate, 3))
        else $error("bypass output does not follow input");
    a_debounce_hold:
    assert property ($changed(o_cmp_filtered) && sel_reg != 3'h0 |->
        hold_reg + 9'h002 >= (9'h001 << sel_reg))
        else $error("filtered output changed too early");
    a_rdata_idle:
    assert property (!$past(i_read) |-> o_rdata == 8'h00)
        else $error("read data not zero outside read");
    a_unity_switch:
    assert property (i_write && i_addr == 3'h3 |=> o_unity_buffer == ($past(i_wdata[6:4]) == 3'h0))
        else $error("unity buffer flag wrong");
endmodule
bind pct_top pct_top_asserts pct_top_asserts_i (.i_clock, .i_rst_n, .i_addr, .i_wdata, .i_write,
    .i_read, .o_rdata, .i_cmp_analog, .o_cmp_filtered, .o_protect_enable, .o_dac_code,
    .o_unity_buffer, .o_amp_cal_mode, .o_amp_cal_ref_select, .o_amp_trim, .o_cmp_cal_mode,
    .o_cmp_cal_ref_select, .o_cmp_trim);

// ---- tb/test_pct_top.sv ----
// Self-checking bench for the protection comparator trim block
`timescale 1ns/1ps
module test_pct_top;
    import pct_pkg::*;
    logic i_clock = 0, i_rst_n = 0, i_write = 0, i_read = 0, i_cmp_analog = 0;
    logic [2:0] i_addr = 0;
    logic [7:0] i_wdata = 0, o_rdata, o_dac_code, o_analog_switch_ctrl, r;
    logic o_cmp_filtered, o_protect_enable, o_dac_vref_select, o_unity_buffer;
    logic o_hysteresis_enable, o_cmp_plus_input_select, o_amp_cal_mode, o_amp_cal_ref_select;
    logic o_cmp_cal_mode, o_cmp_cal_ref_select, lvl = 0;
    logic [5:0] o_amp_trim;
    logic [4:0] o_cmp_trim;
    int n_errors = 0, num_checks = 0, md = 0, thr = 0, avg, k;
    int unsigned seed = 21317;
    // Register model: stored bits per index, masks drop read-only or absent bits
    logic [7:0] m[8] = '{8'h00, 8'h20, 8'h10, 8'hC8, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] msk[8] = '{8'hFF, 8'hFF, 8'h7F, 8'hFF, 8'hC3, 8'h07, 8'h00, 8'h00};
    pct_top pct_top_i (.i_clock, .i_rst_n, .i_addr, .i_wdata, .i_write, .i_read, .o_rdata,
        .i_cmp_analog, .o_cmp_filtered, .o_protect_enable, .o_dac_code, .o_dac_vref_select,
        .o_analog_switch_ctrl, .o_unity_buffer, .o_hysteresis_enable, .o_cmp_plus_input_select,
        .o_amp_cal_mode, .o_amp_cal_ref_select, .o_amp_trim, .o_cmp_cal_mode,
        .o_cmp_cal_ref_select, .o_cmp_trim);
    initial
    begin
        forever #2.5 i_clock = ~i_clock;
    end
    // Analog stand-in: fixed level, or a trim that crosses a hidden threshold
    always @(posedge i_clock)
        i_cmp_analog <= md == 0 ? lvl : (md == 1 ? o_amp_trim >= thr : o_cmp_trim >= thr);
    function automatic int unsigned rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Bus cycles end with one idle edge so strobes never toggle twice in a step
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_write <= 1'b1;
        @(posedge i_clock);
        i_write <= 1'b0;
        m[a] = d & msk[a];
        @(posedge i_clock);
    endtask
    task automatic rd(input logic [2:0] a);
        repeat (2) @(posedge i_clock);
        i_addr <= a;
        i_read <= 1'b1;
        @(posedge i_clock);
        i_read <= 1'b0;
        #1 r = o_rdata;
        @(posedge i_clock);
    endtask
    // Software sweep up from zero and down from all ones, then the average
    task automatic sweep(input logic [2:0] a, input logic [7:0] hi, input int mx);
        int v1, v2;
        logic b;
        v1 = 0;
        v2 = 0;
        // The raw compare bit lives in the comparator register for both sweeps
        wr(a, hi);
        rd(3'h2);
        b = r[7];
        for (int v = 1; v <= mx && v1 == 0; v++)
        begin
            wr(a, hi | 8'(v));
            rd(3'h2);
            if (r[7] !== b)
                v1 = v;
        end
        wr(a, hi | 8'(mx));
        rd(3'h2);
        b = r[7];
        for (int v = mx - 1; v >= 0 && v2 == 0; v--)
        begin
            wr(a, hi | 8'(v));
            rd(3'h2);
            if (r[7] !== b)
                v2 = v;
        end
        wr(a, hi | 8'((v1 + v2) / 2));
    endtask
    task automatic conclude();
        if (n_errors == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(posedge i_clock);
        i_rst_n <= 1'b1;
        // Reset values and unmapped indices
        for (int a = 0; a < 8; a++)
        begin
            rd(3'(a));
            chk(r, m[a]);
        end
        // Random register traffic, read back and port copies
        for (int n = 0; n < 24; n++)
        begin
            k = rnd() % 8;
            k = (k == 4) ? 3 : k;
            wr(3'(k), 8'(rnd()));
            rd(3'(k));
            chk(r, m[k]);
            chk(o_dac_code, m[0]);
            chk({o_amp_cal_mode, o_amp_cal_ref_select, o_amp_trim}, m[1]);
            chk({1'b0, o_cmp_cal_mode, o_cmp_cal_ref_select, o_cmp_trim}, m[2]);
            chk({7'h00, o_unity_buffer}, {7'h00, m[3][6:4] == 3'h0});
            chk(o_analog_switch_ctrl, m[3]);
        end
        // Amplifier calibration sweep
        wr(3'h3, 8'h28);
        wr(3'h1, 8'hC0);
        wr(3'h2, 8'h00);
        wr(3'h4, 8'h80);
        wr(3'h0, 8'h40);
        thr = 1 + rnd() % 62;
        md = 1;
        sweep(3'h1, 8'hC0, 63);
        chk({2'h0, o_amp_trim}, 8'(thr - 1));
        // Comparator calibration sweep, hysteresis kept off
        wr(3'h2, 8'h40);
        wr(3'h1, 8'h00);
        thr = 1 + rnd() % 30;
        md = 2;
        sweep(3'h2, 8'h40, 31);
        chk({3'h0, o_cmp_trim}, 8'(thr - 1));
        // Debounce: long level passed for every select, short pulse rejected for selects two and up
        md = 0;
        for (int s = 0; s < 8; s++)
        begin
            wr(3'h5, 8'(s));
            repeat (8) @(posedge i_clock);
            if (s > 1)
            begin
                lvl <= 1'b1;
                repeat ((1 << s) - 2) @(posedge i_clock);
                lvl <= 1'b0;
                repeat ((1 << s) + 8) @(posedge i_clock);
                chk({7'h00, o_cmp_filtered}, 8'h00);
            end
            lvl <= 1'b1;
            repeat ((1 << s) + 6) @(posedge i_clock);
            chk({7'h00, o_cmp_filtered}, 8'h01);
            lvl <= 1'b0;
            repeat ((1 << s) + 6) @(posedge i_clock);
            chk({7'h00, o_cmp_filtered}, 8'h00);
        end
        lvl <= 1'b1;
        repeat (140) @(posedge i_clock);
        rd(3'h4);
        chk(r, 8'hA0);
        wr(3'h4, 8'h00);
        repeat (140) @(posedge i_clock);
        chk({7'h00, o_cmp_filtered}, 8'h00);
        rd(3'h2);
        chk(r, m[2]);
        // Control port copies with hysteresis and both select bits set, enable low
        wr(3'h4, 8'h43);
        chk({o_protect_enable, o_hysteresis_enable, 4'h0, o_cmp_plus_input_select,
            o_dac_vref_select}, m[4]);
        conclude();
    end
endmodule
